/* design/csc_pkg.sv */
// Shared constants and types of the clock source and start-up control block
package csc_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PLL = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_FUSE = 8'h10;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SLEEP_BIT = 4;
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_DIV_LSB = 4;

  // Reset values of software fields
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic PLL_EN_RST = 1'b0;
  localparam logic [3:0] PLL_DIV_RST = 4'h0;
  localparam logic [6:0] ADDR_RST = 7'h00;

  // Factory fuse state; a fuse bit reads 1 when unprogrammed
  localparam logic [3:0] FUSE_CLOCK_SOURCE_SELECT_DEF = 4'hf;
  localparam logic [1:0] FUSE_SUT_DEF = 2'h2;
  localparam logic FUSE_DIV8_DEF = 1'b0;

  // USB PLL: fixed multiplier, output and required input rate
  localparam int PLL_MULT = 24;
  localparam int USB_KHZ = 48000;
  localparam int PLL_IN_KHZ = USB_KHZ / PLL_MULT;

  // Reset time-out, in watchdog oscillator cycles
  localparam logic [13:0] TOUT_NONE = 14'h0000;
  localparam logic [13:0] TOUT_SHORT = 14'h0200;
  localparam logic [13:0] TOUT_LONG = 14'h2000;

  // Oscillator start-up counts, in selected oscillator cycles
  localparam logic [15:0] OSC_CK6 = 16'h0006;
  localparam logic [15:0] OSC_258 = 16'h0102;
  localparam logic [15:0] OSC_1K = 16'h0400;
  localparam logic [15:0] OSC_16K = 16'h4000;
  localparam logic [15:0] OSC_32K = 16'h8000;
  localparam logic [15:0] RESET_EXTRA_CK = 16'h000e;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_TIMEOUT = 3'b010,
    ST_OSC = 3'b011,
    ST_RUN = 3'b100,
    ST_SLEEP = 3'b101,
    ST_HOLD = 3'b110
  } csc_state_t;

  typedef enum logic [1:0] {
    SLP_IDLE = 2'b00,
    SLP_ADCNR = 2'b01,
    SLP_PDOWN = 2'b10,
    SLP_PSAVE = 2'b11
  } csc_sleep_t;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_RC = 2'b01,
    SRC_LFX = 2'b10,
    SRC_LPX = 2'b11
  } csc_src_t;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

endpackage

/* design/csc_tick_counter.sv */
// Start-up cycle counter advanced by an oscillator tick
`timescale 1ns/1ps
module csc_tick_counter #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic start, // Clears and starts a count
  input wire logic tick, // One pulse per oscillator cycle
  input wire logic [WIDTH-1:0] terminal, // Cycles to count
  output logic done // High once the count has completed
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [WIDTH-1:0] cnt;
  } csc_cnt_state_t;

  csc_cnt_state_t r;
  csc_cnt_state_t next_r;

  always_comb begin
    next_r = r;
    if (start) begin
      next_r.cnt = '0;
      next_r.busy = (terminal != '0);
      next_r.done = (terminal == '0);
    end else if (r.busy && tick) begin
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt + 1'b1 == terminal) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
endmodule

/* design/csc_clock_ctrl.sv */
// Clock source selection, domain gating and start-up sequencer
`timescale 1ns/1ps
module csc_clock_ctrl #(
  parameter int NUM_INT = 8,
  parameter logic [NUM_INT-1:0] ASYNC_INT_MASK = 8'h0f,
  parameter int OSC_KHZ = 16000
) (
  input wire logic core_clk, // 50 MHz system clock
  input wire logic resetn, // Power-on reset, active low
  input wire logic ext_reset_n, // Other reset sources, low while any holds
  input wire logic [3:0] fuse_clock_source_select, // Clock source fuses
  input wire logic [1:0] fuse_startup_time_select, // Start-up fuses
  input wire logic fuse_divide_by_eight, // Prescale fuse, 0 = programmed
  input wire logic wdt_osc_tick, // One pulse per watchdog oscillator cycle
  input wire logic osc_tick, // One pulse per selected oscillator cycle
  input wire logic [NUM_INT-1:0] ext_int, // External interrupt levels
  input wire logic addr_strobe, // Serial slave address byte valid
  input wire logic [6:0] addr_byte, // Received serial slave address
  input wire logic [7:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI write strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [7:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  output logic core_clock_en, // Core clock gate enable
  output logic flash_if_clock_en, // Flash interface clock gate enable
  output logic peripheral_clock_en, // Peripheral clock gate enable
  output logic async_timer_clock_en, // Asynchronous timer clock enable
  output logic converter_clock_en, // Converter clock enable
  output logic usb_pll_clock_en, // USB PLL clock enable
  output logic internal_reset_n, // Internal reset, active low
  output logic [1:0] osc_source, // Selected oscillator kind
  output logic [1:0] lp_freq_mode, // Low power crystal frequency range
  output logic addr_match // Pulse on own serial address seen
);
  typedef struct packed {
    csc_pkg::csc_state_t state;
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic div8_fuse;
    logic from_reset;
    logic [2:0] pre_cnt;
    csc_pkg::csc_sleep_t mode;
    logic pll_en;
    logic [3:0] pll_div;
    logic [6:0] own_addr;
    logic [1:0] wake_cause;
    logic core_en;
    logic flash_en;
    logic io_en;
    logic asy_en;
    logic adc_en;
    logic usb_en;
    logic rst_n;
    logic [1:0] src;
    logic [1:0] lp_mode;
    logic addr_hit;
    logic tout_start;
    logic osc_start;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csc_ctrl_state_t;

  csc_ctrl_state_t r;
  csc_ctrl_state_t next_r;
  logic tout_done;
  logic osc_done;
  logic [15:0] osc_terminal;

  // Source kind from the clock select fuses; reserved codes fall back to RC
  function automatic logic [1:0] src_kind(input logic [3:0] ck);
    if (ck[3]) begin
      src_kind = csc_pkg::SRC_LPX;
    end else if (ck[3:1] == 3'b010) begin
      src_kind = csc_pkg::SRC_LFX;
    end else if (ck == 4'b0000) begin
      src_kind = csc_pkg::SRC_EXT;
    end else begin
      src_kind = csc_pkg::SRC_RC;
    end
  endfunction

  function automatic logic src_reserved(input logic [3:0] ck);
    src_reserved = (ck[3:1] == 3'b011) || (ck == 4'b0011) || (ck == 4'b0001);
  endfunction

  function automatic logic [13:0] tout_cycles(input logic [3:0] ck, input logic [1:0] startup_time_select);
    tout_cycles = csc_pkg::TOUT_NONE;
    if (ck[3]) begin
      case ({ck[0], startup_time_select})
        3'b000, 3'b011, 3'b110: tout_cycles = csc_pkg::TOUT_SHORT;
        3'b001, 3'b100, 3'b111: tout_cycles = csc_pkg::TOUT_LONG;
        default: tout_cycles = csc_pkg::TOUT_NONE;
      endcase
    end else begin
      case (startup_time_select)
        2'b01: tout_cycles = csc_pkg::TOUT_SHORT;
        2'b10: tout_cycles = csc_pkg::TOUT_LONG;
        default: tout_cycles = csc_pkg::TOUT_NONE;
      endcase
    end
  endfunction

  function automatic logic [15:0] osc_cycles(input logic [3:0] ck, input logic [1:0] startup_time_select);
    osc_cycles = csc_pkg::OSC_CK6;
    if (ck[3]) begin
      case ({ck[0], startup_time_select})
        3'b000, 3'b001: osc_cycles = csc_pkg::OSC_258;
        3'b010, 3'b011, 3'b100: osc_cycles = csc_pkg::OSC_1K;
        default: osc_cycles = csc_pkg::OSC_16K;
      endcase
    end else if (ck[3:1] == 3'b010) begin
      osc_cycles = ck[0] ? csc_pkg::OSC_32K : csc_pkg::OSC_1K;
    end
  endfunction

  logic pll_ok;
  logic int_wake;
  logic addr_seen;
  logic div8_on;
  logic [7:0] rd_addr;

  // A bad prescale keeps the USB clock off rather than run it off-rate
  assign pll_ok = ((32'(r.pll_div) + 32'd1) * csc_pkg::PLL_IN_KHZ) == OSC_KHZ;
  // With the peripheral clock halted only the async-detected lines can wake
  assign int_wake = |(ext_int & (r.io_en ? {NUM_INT{1'b1}} : ASYNC_INT_MASK));
  assign addr_seen = addr_strobe && (addr_byte == r.own_addr);
  assign div8_on = !r.div8_fuse;
  assign rd_addr = araddr;
  // Wake-up adds the 14-cycle reset extra only on the reset path
  assign osc_terminal = osc_cycles(r.clock_source_select, r.startup_time_select) +
    (r.from_reset ? csc_pkg::RESET_EXTRA_CK : 16'h0000);

  csc_tick_counter #(.WIDTH(14)) u_tout (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(r.tout_start),
    .tick(wdt_osc_tick),
    .terminal(tout_cycles(r.clock_source_select, r.startup_time_select)),
    .done(tout_done)
  );

  csc_tick_counter #(.WIDTH(16)) u_osc (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(r.osc_start),
    .tick(osc_tick),
    .terminal(osc_terminal),
    .done(osc_done)
  );

  always_comb begin
    next_r = r;
    next_r.tout_start = 1'b0;
    next_r.osc_start = 1'b0;
    next_r.addr_hit = addr_seen;
    case (r.state)
      csc_pkg::ST_POR: begin
        next_r.state = csc_pkg::ST_SAMPLE;
      end
      csc_pkg::ST_SAMPLE: begin
        // Captured once here and never again until power-on reset
        next_r.clock_source_select = fuse_clock_source_select;
        next_r.startup_time_select = fuse_startup_time_select;
        next_r.div8_fuse = fuse_divide_by_eight;
        next_r.from_reset = 1'b1;
        if (ext_reset_n) begin
          next_r.tout_start = 1'b1;
          next_r.state = csc_pkg::ST_TIMEOUT;
        end else begin
          next_r.state = csc_pkg::ST_HOLD;
        end
      end
      csc_pkg::ST_HOLD: begin
        if (ext_reset_n) begin
          next_r.from_reset = 1'b1;
          next_r.tout_start = 1'b1;
          next_r.state = csc_pkg::ST_TIMEOUT;
        end
      end
      csc_pkg::ST_TIMEOUT: begin
        if (tout_done && !r.tout_start) begin
          next_r.osc_start = 1'b1;
          next_r.state = csc_pkg::ST_OSC;
        end
      end
      csc_pkg::ST_OSC: begin
        if (osc_done && !r.osc_start) begin
          next_r.state = csc_pkg::ST_RUN;
        end
      end
      csc_pkg::ST_RUN: begin
        if (r.awready == 1'b0 && r.aw_held && r.w_held && !r.bvalid &&
            r.waddr == csc_pkg::REG_CTRL && r.wstrb0 && r.wbyte[csc_pkg::CTRL_SLEEP_BIT]) begin
          next_r.wake_cause = 2'b00;
          next_r.state = csc_pkg::ST_SLEEP;
        end
      end
      csc_pkg::ST_SLEEP: begin
        if (int_wake || addr_seen) begin
          next_r.wake_cause = {addr_seen, int_wake};
          if (r.mode == csc_pkg::SLP_PDOWN || r.mode == csc_pkg::SLP_PSAVE) begin
            // Supply is assumed good after deep sleep: no time-out
            next_r.from_reset = 1'b0;
            next_r.osc_start = 1'b1;
            next_r.state = csc_pkg::ST_OSC;
          end else begin
            next_r.state = csc_pkg::ST_RUN;
          end
        end
      end
      default: begin
        next_r.state = csc_pkg::ST_POR;
      end
    endcase
    if (!ext_reset_n && r.state != csc_pkg::ST_POR && r.state != csc_pkg::ST_SAMPLE) begin
      next_r.state = csc_pkg::ST_HOLD;
    end

    // System clock prescaler; divide by eight when that fuse is programmed
    next_r.pre_cnt = (next_r.state == csc_pkg::ST_RUN) ? r.pre_cnt + 3'h1 : 3'h0;
    next_r.core_en = (next_r.state == csc_pkg::ST_RUN) &&
      (!div8_on || next_r.pre_cnt == 3'h0);
    next_r.flash_en = next_r.core_en;
    next_r.usb_en = (next_r.state == csc_pkg::ST_RUN) && r.pll_en && pll_ok;
    next_r.rst_n = (next_r.state == csc_pkg::ST_RUN) || (next_r.state == csc_pkg::ST_SLEEP);
    next_r.src = src_kind(r.clock_source_select);
    next_r.lp_mode = r.clock_source_select[3] ? r.clock_source_select[2:1] : 2'b00;

    // AXI4-Lite write channel: address and data taken in either order
    if (awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.aw_held = 1'b1;
      next_r.waddr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.w_held = 1'b1;
      next_r.wbyte = wdata[7:0];
      next_r.wstrb0 = wstrb[0];
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = csc_pkg::AXI_OKAY;
      case (r.waddr)
        csc_pkg::REG_CTRL: begin
          if (r.wstrb0) begin
            next_r.mode = csc_pkg::csc_sleep_t'(r.wbyte[csc_pkg::CTRL_MODE_LSB +: 2]);
          end
        end
        csc_pkg::REG_PLL: begin
          if (r.wstrb0) begin
            next_r.pll_en = r.wbyte[csc_pkg::PLL_EN_BIT];
            next_r.pll_div = r.wbyte[csc_pkg::PLL_DIV_LSB +: 4];
          end
        end
        csc_pkg::REG_ADDR: begin
          if (r.wstrb0) begin
            next_r.own_addr = r.wbyte[6:0];
          end
        end
        csc_pkg::REG_STATUS, csc_pkg::REG_FUSE: begin
          next_r.bresp = csc_pkg::AXI_OKAY;
        end
        default: begin
          next_r.bresp = csc_pkg::AXI_SLVERR;
        end
      endcase
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // Gate on the mode that lands with the sleep write, so the first sleep cycle is right
    next_r.io_en = (next_r.state == csc_pkg::ST_RUN) ||
      (next_r.state == csc_pkg::ST_SLEEP && next_r.mode == csc_pkg::SLP_IDLE);
    next_r.adc_en = (next_r.state == csc_pkg::ST_RUN) ||
      (next_r.state == csc_pkg::ST_SLEEP &&
       (next_r.mode == csc_pkg::SLP_IDLE || next_r.mode == csc_pkg::SLP_ADCNR));
    next_r.asy_en = (next_r.state == csc_pkg::ST_RUN) ||
      (next_r.state == csc_pkg::ST_SLEEP && next_r.mode != csc_pkg::SLP_PDOWN);

    // AXI4-Lite read channel
    if (arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = csc_pkg::AXI_OKAY;
      next_r.rdata = 32'h0000_0000;
      case (rd_addr)
        csc_pkg::REG_CTRL: next_r.rdata[1:0] = r.mode;
        csc_pkg::REG_PLL: next_r.rdata[7:0] = {r.pll_div, 3'h0, r.pll_en};
        csc_pkg::REG_ADDR: next_r.rdata[6:0] = r.own_addr;
        csc_pkg::REG_STATUS: next_r.rdata[18:0] = {r.wake_cause, r.usb_en, r.asy_en,
          r.adc_en, r.io_en, pll_ok, 1'b0, r.clock_source_select[3:1], r.startup_time_select == 2'b11 && !r.clock_source_select[3],
          src_reserved(r.clock_source_select), src_kind(r.clock_source_select), div8_on, r.state};
        csc_pkg::REG_FUSE: next_r.rdata[6:0] = {r.div8_fuse, r.startup_time_select, r.clock_source_select};
        default: next_r.rresp = csc_pkg::AXI_SLVERR;
      endcase
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.state <= csc_pkg::ST_POR;
      r.clock_source_select <= csc_pkg::FUSE_CLOCK_SOURCE_SELECT_DEF;
      r.startup_time_select <= csc_pkg::FUSE_SUT_DEF;
      r.div8_fuse <= csc_pkg::FUSE_DIV8_DEF;
      r.mode <= csc_pkg::csc_sleep_t'(csc_pkg::CTRL_MODE_RST);
      r.pll_en <= csc_pkg::PLL_EN_RST;
      r.pll_div <= csc_pkg::PLL_DIV_RST;
      r.own_addr <= csc_pkg::ADDR_RST;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign core_clock_en = r.core_en;
  assign flash_if_clock_en = r.flash_en;
  assign peripheral_clock_en = r.io_en;
  assign async_timer_clock_en = r.asy_en;
  assign converter_clock_en = r.adc_en;
  assign usb_pll_clock_en = r.usb_en;
  assign internal_reset_n = r.rst_n;
  assign osc_source = r.src;
  assign lp_freq_mode = r.lp_mode;
  assign addr_match = r.addr_hit;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_deep_sleep;
    r.state == csc_pkg::ST_SLEEP &&
      (r.mode == csc_pkg::SLP_PDOWN || r.mode == csc_pkg::SLP_PSAVE);
  endsequence

  sequence s_wake_seen;
    (int_wake || addr_seen) && ext_reset_n;
  endsequence

  chk_core_halt_sleep: assert property (
    core_clock_en |-> r.state == csc_pkg::ST_RUN && internal_reset_n)
    else $error("core clock enabled outside run");
  chk_flash_with_core: assert property (
    flash_if_clock_en == core_clock_en)
    else $error("flash clock not gated with core clock");
  chk_async_int_wake: assert property (
    s_deep_sleep ##0 (|(ext_int & ASYNC_INT_MASK)) && ext_reset_n |=> r.state == csc_pkg::ST_OSC)
    else $error("masked interrupt failed to wake");
  chk_addr_match_sleep: assert property (
    addr_seen |=> addr_match)
    else $error("own address not recognised");
  chk_addr_wake_sleep: assert property (
    r.state == csc_pkg::ST_SLEEP && addr_seen && ext_reset_n |=>
      addr_match && r.state != csc_pkg::ST_SLEEP)
    else $error("own address did not wake from sleep");
  chk_asy_runs_save: assert property (
    r.state == csc_pkg::ST_SLEEP && r.mode == csc_pkg::SLP_PSAVE |-> async_timer_clock_en)
    else $error("async timer clock off in power-save");
  chk_adc_noise_mode: assert property (
    r.state == csc_pkg::ST_SLEEP && r.mode == csc_pkg::SLP_ADCNR ##1 r.state == csc_pkg::ST_SLEEP
    |-> converter_clock_en && !peripheral_clock_en && !core_clock_en)
    else $error("noise reduction sleep gating wrong");
  chk_pll_input_rate: assert property (
    usb_pll_clock_en |-> $past(pll_ok) && $past(r.pll_en))
    else $error("USB clock on with bad PLL input");
  chk_reset_held_count: assert property (
    r.state == csc_pkg::ST_TIMEOUT || r.state == csc_pkg::ST_OSC |-> !internal_reset_n)
    else $error("internal reset released during start-up");
  chk_wake_skips_tout: assert property (
    s_deep_sleep ##0 s_wake_seen |=> r.state == csc_pkg::ST_OSC ##1 !r.from_reset)
    else $error("deep sleep wake did not skip time-out");
  chk_fuse_held_run: assert property (
    r.state == csc_pkg::ST_RUN ##1 r.state == csc_pkg::ST_RUN |-> $stable(r.clock_source_select) && $stable(r.startup_time_select))
    else $error("fuse copy changed during operation");
endmodule

/* testbench/csc_osc_model.sv */
// Tick source standing in for the selected oscillator and the watchdog oscillator
`timescale 1ns/1ps
module csc_osc_model (
  input wire logic core_clk, // System clock
  input wire logic resetn, // Reset, active low
  output logic osc_tick, // One pulse every second cycle
  output logic wdt_osc_tick // One pulse every third cycle
);
  logic [1:0] wph;
  // Distinct rates let the bench tell the two start-up counts apart
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_tick <= 1'b0;
      wph <= 2'h0;
      wdt_osc_tick <= 1'b0;
    end else begin
      osc_tick <= ~osc_tick;
      wph <= (wph == 2'h2) ? 2'h0 : wph + 2'h1;
      wdt_osc_tick <= (wph == 2'h2);
    end
  end
endmodule

/* testbench/test_clock_source_and_startup_control.sv */
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module test_clock_source_and_startup_control;
  logic core_clk = 0;
  logic resetn = 0;
  logic ext_reset_n = 1;
  logic [3:0] cks = 4'hf;
  logic [1:0] startup_time_select = 2'h2;
  logic div8 = 0;
  logic [7:0] ext_int = 8'h00;
  logic addr_strobe = 0;
  logic [6:0] addr_byte = 7'h00;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rsp, src, lpm;
  logic awready, wready, bvalid, arready, rvalid, ce, fe, pe, ae, cve, ue, irn, am;
  logic osc_tick, wdt_osc_tick;
  logic [6:0] own;
  int error_cnt = 0, checks = 0, n;
  initial forever #10 core_clk = ~core_clk;
  csc_osc_model csc_osc_model_i (.core_clk(core_clk), .resetn(resetn), .osc_tick(osc_tick),
    .wdt_osc_tick(wdt_osc_tick));
  csc_clock_ctrl csc_clock_ctrl_i (.core_clk(core_clk), .resetn(resetn),
    .ext_reset_n(ext_reset_n), .fuse_clock_source_select(cks), .fuse_startup_time_select(startup_time_select),
    .fuse_divide_by_eight(div8), .wdt_osc_tick(wdt_osc_tick), .osc_tick(osc_tick),
    .ext_int(ext_int), .addr_strobe(addr_strobe), .addr_byte(addr_byte), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .core_clock_en(ce), .flash_if_clock_en(fe), .peripheral_clock_en(pe),
    .async_timer_clock_en(ae), .converter_clock_en(cve), .usb_pll_clock_en(ue),
    .internal_reset_n(irn), .osc_source(src), .lp_freq_mode(lpm), .addr_match(am));
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic ck(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) bad(m);
  endtask
  task automatic bound(input int lim);
    n++;
    if (n > lim) begin
      bad("wait limit");
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      bound(50);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      bound(50);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask
  // Reference start-up tables: time-out in watchdog ticks, start-up in oscillator ticks
  function automatic int tout(input logic [3:0] c, input logic [1:0] s);
    int k;
    k = {c[0], s};
    if (c[3]) return (k == 2 || k == 5) ? 0 : (k % 3 == 0) ? 512 : 8192;
    return (s == 2'h1) ? 512 : (s == 2'h2) ? 8192 : 0;
  endfunction
  function automatic int osc(input logic [3:0] c, input logic [1:0] s);
    int k;
    k = {c[0], s};
    if (c[3]) return (k < 2) ? 258 : (k < 5) ? 1024 : 16384;
    if (c[3:1] == 3'b010) return c[0] ? 32768 : 1024;
    return 6;
  endfunction
  // Tick phase and the sampling edges give a few cycles of slack either way
  task automatic meas(input int e);
    n = 0;
    do begin
      @(posedge core_clk);
      bound(100000);
    end while (irn !== 1'b1);
    ck(n >= e - 6 && n <= e + 16, "start-up length");
  endtask
  task automatic wake(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge core_clk);
      bound(300);
    end while (ce !== 1'b1);
    ck(n >= lo && n <= hi, "wake length");
  endtask
  task automatic st(input logic [3:0] c, input logic [1:0] s, input logic d);
    cks <= c;
    startup_time_select <= s;
    div8 <= d;
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    meas(tout(c, s) * 3 + (osc(c, s) + 14) * 2);
    ck(src === (c[3] ? 2'h3 : (c[3:1] == 3'b010) ? 2'h2 : (c == 0) ? 2'h0 : 2'h1), "src");
    ck(lpm === (c[3] ? c[2:1] : 2'h0), "lp mode");
    rdr(csc_pkg::REG_FUSE);
    ck(rd[6:0] === {d, s, c}, "fuse copy");
    n = 0;
    repeat (16) begin
      @(posedge core_clk);
      n += (ce === 1'b1);
      ck(fe === ce, "flash gate");
    end
    ck(n == (d ? 16 : 2), "core gate");
  endtask
  initial begin
    n = $urandom(53);
    st(4'hf, 2'h2, 1'b0);
    st(4'h0, 2'h0, 1'b1);
    st(4'h3, 2'h3, 1'b1);
    st(4'h4, 2'h2, 1'b1);
    st(4'h8, 2'h0, 1'b1);
    st(4'ha, 2'h3, 1'b1);
    st(4'h2, 2'h1, 1'b1);
    // New fuse levels must not be taken up by a later non-power-on reset
    cks <= 4'h4;
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    ck(irn === 1'b0, "other reset held");
    ext_reset_n <= 1'b1;
    meas(512 * 3 + 40);
    own = 7'($urandom);
    wr(csc_pkg::REG_ADDR, {25'h0, own});
    wr(csc_pkg::REG_CTRL, 32'h12);
    @(posedge core_clk);
    ck({ce, fe, pe, ae, cve} === 5'h0, "power-down gates");
    ext_int <= 8'h80;
    addr_byte <= own ^ 7'(1 + $urandom % 127);
    addr_strobe <= 1'b1;
    @(posedge core_clk);
    addr_strobe <= 1'b0;
    repeat (20) @(posedge core_clk);
    ck(ce === 1'b0, "false wake");
    ext_int <= 8'h00;
    addr_byte <= own;
    addr_strobe <= 1'b1;
    @(posedge core_clk);
    addr_strobe <= 1'b0;
    @(posedge core_clk);
    ck(am === 1'b1, "address match");
    wake(6, 22);
    for (int m = 0; m < 4; m++) begin
      wr(csc_pkg::REG_CTRL, 32'h10 | m);
      @(posedge core_clk);
      ck({ce, pe, ae, cve} === {1'b0, m == 0, m != 2, m < 2}, "sleep gates");
      ext_int <= 8'h01;
      wake(1, (m < 2) ? 3 : 22);
      ext_int <= 8'h00;
    end
    for (int p = 0; p < 16; p++) begin
      wr(csc_pkg::REG_PLL, {24'h0, 4'(p), 4'h1});
      @(posedge core_clk);
      ck(ue === ((p + 1) * csc_pkg::PLL_IN_KHZ == 16000), "pll gate");
    end
    wr(csc_pkg::REG_FUSE, 32'h0);
    ck(rsp === csc_pkg::AXI_OKAY, "fuse write response");
    rdr(csc_pkg::REG_FUSE);
    ck(rd[6:0] === {div8, startup_time_select, 4'h2}, "fuse write");
    rdr(csc_pkg::REG_STATUS);
    ck(rd[5:0] === {csc_pkg::SRC_RC, 1'b0, csc_pkg::ST_RUN}, "status");
    rdr(8'h14);
    ck(rsp === csc_pkg::AXI_SLVERR, "unmapped");
    final_report();
  end
endmodule
